// [include/scd_pkg.sv]
// package: shared constants and types for the servo command input decoder
package scd_pkg;

  // ----------------------------------------
  // register map (APB, byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0C;
  localparam logic [7:0] ADDR_ABS = 8'h10;

  // ----------------------------------------
  // mode input function and pulse format encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    MF_PROP = 3'h0,
    MF_DIR = 3'h1,
    MF_MODESW = 3'h2,
    MF_ZCLAMP = 3'h3,
    MF_INHIBIT = 3'h4
  } scd_mf_t;

  typedef enum logic [1:0] {
    PF_STEPDIR = 2'h0,
    PF_CWCCW = 2'h1,
    PF_QUAD = 2'h2
  } scd_pf_t;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_MF_LSB = 0;
  localparam int CFG_PF_LSB = 3;
  localparam int CFG_INTSPD_BIT = 5;
  localparam int CFG_SWAPOT_BIT = 6;
  localparam int CFG_SWAPCL_BIT = 7;
  localparam int CFG_ABSENC_BIT = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_US = 1;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int SEQ_N = 8;

endpackage

// [include/scd_if.sv]
// interface: sequence and pulse command pins between host and servo amplifier
interface scd_if;
  logic enableIn;
  logic modeIn;
  logic fwdLimit;
  logic revLimit;
  logic fwdTorqueLimit;
  logic revTorqueLimit;
  logic faultClear;
  logic encDataRequest;
  logic stepIn;
  logic signIn;
  logic errClear;
  logic encDataValid;
  logic [31:0] encData;
  logic alarm;

  modport host (
    output enableIn, modeIn, fwdLimit, revLimit, fwdTorqueLimit, revTorqueLimit,
    output faultClear, encDataRequest, stepIn, signIn, errClear,
    input encDataValid, encData, alarm
  );
  modport device (
    input enableIn, modeIn, fwdLimit, revLimit, fwdTorqueLimit, revTorqueLimit,
    input faultClear, encDataRequest, stepIn, signIn, errClear,
    output encDataValid, encData, alarm
  );
endinterface

// [hdl/scd_device.sv]
// device end: decodes sequence and pulse command inputs of the servo amplifier
// ----------------------------------------
// Notes on behaviour
// - mode input selects P-only speed loop
// - mode input reverses direction with internal speeds
// - mode input permits paired control-mode change
// - zero clamp forces speed command zero
// - pulse inhibit ignores command pulses
// - travel limit stops motor that direction
// - torque-limit input applies direction current limit
// - internal speeds: torque inputs select speed
// - fault clear releases latched alarm
// - encoder request answered with absolute data
// - step/dir, CW/CCW, quadrature pulse formats
// - error clear zeroes position error counter
// - configuration reassigns sequence input functions
// ----------------------------------------
//
// The register addresses and the APB interface to the registers were left to the implementer.
module scd_device
  import scd_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  scd_if.device link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic faultEvent,
  input wire logic [31:0] absPosition,
  output logic energize,
  output logic piOnly,
  output logic modeSwitchEnable,
  output logic speedZero,
  output logic dirReverse,
  output logic fwdStop,
  output logic revStop,
  output logic fwdCurrentLimit,
  output logic revCurrentLimit,
  output logic [1:0] speedSelect
);

  // ----------------------------------------
  // synchronisers and debounce
  // ----------------------------------------
  logic [SEQ_N-1:0] rawIn;
  logic [SEQ_N-1:0] syncA_reg, syncB_reg, deb_reg;
  logic [2:0] pA_reg, pB_reg;
  logic [15:0] debCnt_reg [SEQ_N];
  assign rawIn = {link.encDataRequest, link.faultClear, link.revTorqueLimit, link.fwdTorqueLimit,
                  link.revLimit, link.fwdLimit, link.modeIn, link.enableIn};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      pA_reg <= '0;
      pB_reg <= '0;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
      pA_reg <= {link.errClear, link.signIn, link.stepIn};
      pB_reg <= pA_reg;
    end
  end

  for (genvar i = 0; i < SEQ_N; i++) begin : g_deb
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        debCnt_reg[i] <= '0;
        deb_reg[i] <= 1'b0;
      end else if (syncB_reg[i] == deb_reg[i]) begin
        debCnt_reg[i] <= '0;
      end else if (debCnt_reg[i] >= 16'(DEB_CYC - 1)) begin
        debCnt_reg[i] <= '0;
        deb_reg[i] <= syncB_reg[i];
      end else begin
        debCnt_reg[i] <= debCnt_reg[i] + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] cfg_reg;
  logic alarm_reg;
  logic [CNT_W-1:0] posErr_reg;
  logic [31:0] absData_reg;
  logic absValid_reg;
  logic [2:0] pPrev_reg;
  logic apbWr, apbRd, clrWrite;
  scd_mf_t mfSel;
  scd_pf_t pfSel;
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mfSel = scd_mf_t'(cfg_reg[CFG_MF_LSB +: 3]);
  assign pfSel = scd_pf_t'(cfg_reg[CFG_PF_LSB +: 2]);
  assign clrWrite = apbWr && paddr == ADDR_CTRL && pwdata[0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else if (apbWr && paddr == ADDR_CFG) begin
      cfg_reg <= pwdata;
    end
  end

  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: prdata = 32'h0000_0000;
      ADDR_CFG: prdata = cfg_reg;
      ADDR_STATUS: prdata = {20'h00000, speedSelect, revCurrentLimit, fwdCurrentLimit, revStop, fwdStop,
                             dirReverse, speedZero, modeSwitchEnable, piOnly, energize, alarm_reg};
      ADDR_POS: prdata = 32'(posErr_reg);
      ADDR_ABS: prdata = absData_reg;
      default: pslverr = psel && penable;
    endcase
    if (!apbRd) prdata = 32'h0000_0000;
  end

  // ----------------------------------------
  // sequence input decode
  // ----------------------------------------
  logic enS, modeS, fLimS, rLimS, fClS, rClS, fcS, reqS, fcPrev_reg, reqPrev_reg;
  assign enS = deb_reg[0];
  assign modeS = deb_reg[1];
  assign fLimS = cfg_reg[CFG_SWAPOT_BIT] ? deb_reg[3] : deb_reg[2];
  assign rLimS = cfg_reg[CFG_SWAPOT_BIT] ? deb_reg[2] : deb_reg[3];
  assign fClS = cfg_reg[CFG_SWAPCL_BIT] ? deb_reg[5] : deb_reg[4];
  assign rClS = cfg_reg[CFG_SWAPCL_BIT] ? deb_reg[4] : deb_reg[5];
  assign fcS = deb_reg[6];
  assign reqS = deb_reg[7];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarm_reg <= 1'b0;
      fcPrev_reg <= 1'b0;
    end else begin
      fcPrev_reg <= fcS;
      if (faultEvent) alarm_reg <= 1'b1;
      else if (fcS && !fcPrev_reg) alarm_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      energize <= 1'b0;
      piOnly <= 1'b0;
      modeSwitchEnable <= 1'b0;
      speedZero <= 1'b0;
      dirReverse <= 1'b0;
      fwdStop <= 1'b0;
      revStop <= 1'b0;
      fwdCurrentLimit <= 1'b0;
      revCurrentLimit <= 1'b0;
      speedSelect <= 2'h0;
    end else begin
      energize <= enS && !alarm_reg && !faultEvent;
      piOnly <= mfSel == MF_PROP && modeS;
      dirReverse <= cfg_reg[CFG_INTSPD_BIT] && mfSel == MF_DIR && modeS;
      modeSwitchEnable <= mfSel == MF_MODESW && modeS;
      speedZero <= mfSel == MF_ZCLAMP && modeS;
      fwdStop <= fLimS;
      revStop <= rLimS;
      fwdCurrentLimit <= !cfg_reg[CFG_INTSPD_BIT] && fClS;
      revCurrentLimit <= !cfg_reg[CFG_INTSPD_BIT] && rClS;
      speedSelect <= cfg_reg[CFG_INTSPD_BIT] ? {rClS, fClS} : 2'h0;
    end
  end

  // ----------------------------------------
  // absolute encoder request
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reqPrev_reg <= 1'b0;
      absData_reg <= 32'h0000_0000;
      absValid_reg <= 1'b0;
    end else begin
      reqPrev_reg <= reqS;
      absValid_reg <= 1'b0;
      if (cfg_reg[CFG_ABSENC_BIT] && reqS && !reqPrev_reg) begin
        absData_reg <= absPosition;
        absValid_reg <= 1'b1;
      end
    end
  end
  assign link.encData = absData_reg;
  assign link.encDataValid = absValid_reg;
  assign link.alarm = alarm_reg;

  // ----------------------------------------
  // pulse command decode and error counter
  // ----------------------------------------
  logic stepRise, dirRise, upCnt, dnCnt, inhibit;
  logic [1:0] qOld, qNew;
  assign stepRise = pB_reg[0] && !pPrev_reg[0];
  assign dirRise = pB_reg[1] && !pPrev_reg[1];
  assign qOld = pPrev_reg[1:0];
  assign qNew = pB_reg[1:0];
  assign inhibit = mfSel == MF_INHIBIT && modeS;

  always_comb begin
    upCnt = 1'b0;
    dnCnt = 1'b0;
    unique case (pfSel)
      PF_STEPDIR: begin
        upCnt = stepRise && !pB_reg[1];
        dnCnt = stepRise && pB_reg[1];
      end
      PF_CWCCW: begin
        upCnt = stepRise && !dirRise;
        dnCnt = dirRise && !stepRise;
      end
      PF_QUAD: begin
        // A leads B counts up, each edge of either phase
        upCnt = (qOld == 2'h0 && qNew == 2'h1) || (qOld == 2'h1 && qNew == 2'h3) ||
                (qOld == 2'h3 && qNew == 2'h2) || (qOld == 2'h2 && qNew == 2'h0);
        dnCnt = (qOld == 2'h1 && qNew == 2'h0) || (qOld == 2'h3 && qNew == 2'h1) ||
                (qOld == 2'h2 && qNew == 2'h3) || (qOld == 2'h0 && qNew == 2'h2);
      end
      default: begin
        upCnt = 1'b0;
        dnCnt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pPrev_reg <= '0;
      posErr_reg <= '0;
    end else begin
      pPrev_reg <= pB_reg;
      if (pB_reg[2] || clrWrite) posErr_reg <= '0;
      else if (!inhibit && upCnt) posErr_reg <= posErr_reg + CNT_W'(1);
      else if (!inhibit && dnCnt) posErr_reg <= posErr_reg - CNT_W'(1);
    end
  end

endmodule

// [hdl/scd_host.sv]
// host end: drives sequence and pulse command pins from APB-programmed registers
module scd_host
  import scd_pkg::*;
#(
  parameter int HALF_CYC = 2
) (
  input wire logic mclk,
  input wire logic rst,
  scd_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------
  // registers: 0x00 sequence levels, 0x04 pulse order, 0x08 status, 0x10 absolute data capture
  // ----------------------------------------
  logic [31:0] seq_reg;
  logic [31:0] absCap_reg;
  logic [15:0] pulseLeft_reg;
  logic [7:0] phase_reg;
  logic [1:0] step_reg;
  logic clrPulse_reg, absSeen_reg, pDir_reg;
  logic [1:0] pFmt_reg;
  logic apbWr;
  assign apbWr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_reg <= 32'h0000_0000;
    end else if (apbWr && paddr == ADDR_CTRL) begin
      seq_reg <= pwdata;
    end
  end

  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: prdata = seq_reg;
      ADDR_CFG: prdata = {14'h0000, pulseLeft_reg, pFmt_reg};
      ADDR_STATUS: prdata = {29'h0000000, link.alarm, absSeen_reg, |pulseLeft_reg};
      ADDR_ABS: prdata = absCap_reg;
      default: pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      absCap_reg <= 32'h0000_0000;
      absSeen_reg <= 1'b0;
    end else if (link.encDataValid) begin
      absCap_reg <= link.encData;
      absSeen_reg <= 1'b1;
    end else if (apbWr && paddr == ADDR_STATUS) begin
      absSeen_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // pulse generator: CFG write = {count[17:2], fmt[1:0]}, bit 31 direction, bit 30 clear pulse
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulseLeft_reg <= 16'h0000;
      phase_reg <= 8'h00;
      step_reg <= 2'h0;
      pFmt_reg <= 2'h0;
      pDir_reg <= 1'b0;
      clrPulse_reg <= 1'b0;
    end else if (apbWr && paddr == ADDR_CFG) begin
      pFmt_reg <= pwdata[1:0];
      pulseLeft_reg <= pwdata[17:2];
      pDir_reg <= pwdata[31];
      clrPulse_reg <= pwdata[30];
      phase_reg <= 8'h00;
    end else if (phase_reg == 8'(HALF_CYC - 1)) begin
      phase_reg <= 8'h00;
      clrPulse_reg <= 1'b0;
      if (pulseLeft_reg != 16'h0000) begin
        step_reg <= step_reg + 2'h1;
        if (step_reg[0] || pFmt_reg == PF_QUAD) pulseLeft_reg <= pulseLeft_reg - 16'h0001;
      end
    end else begin
      phase_reg <= phase_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  logic quadA, quadB;
  // forward lets phase A lead phase B, so the device counts up
  assign quadA = pDir_reg ? step_reg[1] : step_reg[1] ^ step_reg[0];
  assign quadB = pDir_reg ? step_reg[1] ^ step_reg[0] : step_reg[1];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.stepIn <= 1'b0;
      link.signIn <= 1'b0;
    end else begin
      unique case (pFmt_reg)
        PF_STEPDIR: begin
          link.stepIn <= step_reg[0];
          link.signIn <= pDir_reg;
        end
        PF_CWCCW: begin
          link.stepIn <= !pDir_reg && step_reg[0];
          link.signIn <= pDir_reg && step_reg[0];
        end
        default: begin
          link.stepIn <= quadA;
          link.signIn <= quadB;
        end
      endcase
    end
  end

  assign link.enableIn = seq_reg[0];
  assign link.modeIn = seq_reg[1];
  assign link.fwdLimit = seq_reg[2];
  assign link.revLimit = seq_reg[3];
  assign link.fwdTorqueLimit = seq_reg[4];
  assign link.revTorqueLimit = seq_reg[5];
  assign link.faultClear = seq_reg[6];
  assign link.encDataRequest = seq_reg[7];
  assign link.errClear = clrPulse_reg;

endmodule

// [testbench/scd_props.sv]
// checker: timing properties of the host-to-device link
module scd_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stepIn,
  input wire logic signIn,
  input wire logic faultClear,
  input wire logic encDataValid,
  input wire logic [31:0] encData,
  input wire logic alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // encoder answer
  // ----------------------------------------
  property p_valid_pulse;
    encDataValid |=> !encDataValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("encoder valid wider than one cycle");
  property p_data_with_valid;
    $changed(encData) |-> encDataValid;
  endproperty
  a_data_with_valid: assert property (p_data_with_valid) else $error("encoder data moved without valid");
  property p_data_hold;
    encDataValid |=> $stable(encData)[*3];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("encoder data not held");

  // ----------------------------------------
  // alarm and pulses
  // ----------------------------------------
  property p_alarm_release;
    $fell(alarm) |-> faultClear;
  endproperty
  a_alarm_release: assert property (p_alarm_release) else $error("alarm left without fault clear");
  property p_step_high;
    $rose(stepIn) |-> stepIn[*3];
  endproperty
  a_step_high: assert property (p_step_high) else $error("step high too short");
  property p_step_low;
    $fell(stepIn) |-> !stepIn[*3];
  endproperty
  a_step_low: assert property (p_step_low) else $error("step low too short");
  property p_sign_settled;
    $rose(stepIn) |-> $stable(signIn);
  endproperty
  a_sign_settled: assert property (p_sign_settled) else $error("sign moved with step edge");
  property p_reset_quiet;
    $fell(rst) |-> !alarm && !encDataValid && !stepIn;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("link active out of reset");
endmodule

// [testbench/scd_tb_top.sv]
// testbench: host and device ends joined over the link, driven over APB
module scd_tb_top
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] psel = 2'h0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdataD, prdataH, rdv;
  logic preadyD, preadyH, pslverrD, pslverrH, errv;
  logic faultEvent = 1'b0;
  logic [31:0] absPosition = 32'h0;
  logic energize, piOnly, modeSwitchEnable, speedZero, dirReverse, fwdStop, revStop;
  logic fwdCurrentLimit, revCurrentLimit;
  logic [1:0] speedSelect;
  logic [11:0] outV;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] seqT [11] = '{8'h01, 8'h03, 8'h03, 8'h03, 8'h03, 8'h05, 8'h05, 8'h11, 8'h11, 8'h31, 8'h00};
  logic [8:0] cfgT [11] = '{9'h000, 9'h000, 9'h021, 9'h002, 9'h003, 9'h000, 9'h040, 9'h000, 9'h080, 9'h020, 9'h000};
  logic [11:0] expT [11] = '{12'h002, 12'h006, 12'h022, 12'h00A, 12'h012, 12'h042, 12'h082, 12'h102, 12'h202,
    12'hC02, 12'h000};

  scd_if link();
  assign outV = {speedSelect, revCurrentLimit, fwdCurrentLimit, revStop, fwdStop, dirReverse, speedZero,
    modeSwitchEnable, piOnly, energize, link.alarm};
  always #25 mclk = ~mclk;

  scd_device #(.DEB_CYC(8)) scd_device_inst (.mclk(mclk), .rst(rst), .link(link), .psel(psel[0]),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataD), .pready(preadyD),
    .pslverr(pslverrD), .faultEvent(faultEvent), .absPosition(absPosition), .energize(energize),
    .piOnly(piOnly), .modeSwitchEnable(modeSwitchEnable), .speedZero(speedZero), .dirReverse(dirReverse),
    .fwdStop(fwdStop), .revStop(revStop), .fwdCurrentLimit(fwdCurrentLimit),
    .revCurrentLimit(revCurrentLimit), .speedSelect(speedSelect));
  scd_host #(.HALF_CYC(3)) scd_host_inst (.mclk(mclk), .rst(rst), .link(link), .psel(psel[1]),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataH), .pready(preadyH),
    .pslverr(pslverrH));
  scd_props scd_props_inst (.mclk(mclk), .rst(rst), .stepIn(link.stepIn), .signIn(link.signIn),
    .faultClear(link.faultClear), .encDataValid(link.encDataValid), .encData(link.encData), .alarm(link.alarm));

  // ----------------------------------------
  // access and checking tasks
  // ----------------------------------------
  task automatic complete_run;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input int s, input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel[s] <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while ((s ? preadyH : preadyD) !== 1'b1 && n < 20);
    rdv = s ? prdataH : prdataD;
    errv = s ? pslverrH : pslverrD;
    psel <= 2'h0;
    penable <= 1'b0;
    if ((s ? preadyH : preadyD) !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic rd(input string nm, input int s, input logic [7:0] a, input logic [31:0] exp);
    apb(s, 1'b0, a, 32'h0);
    check(nm, rdv, exp);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(1, 1'b0, 8'h08, 32'h0);
      n++;
    end while ((rdv & m) !== e && n < 200);
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic pulses(input logic [1:0] f, input logic d, input logic [31:0] cfg);
    apb(0, 1'b1, 8'h04, cfg | {27'h0, f, 3'h0});
    apb(0, 1'b1, 8'h00, 32'h1);
    apb(1, 1'b1, 8'h04, {d, 13'h0, 16'h5, f});
    poll(32'h1, 32'h0);
    repeat (12) @(posedge mclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd("dev cfg", 0, 8'h04, 32'h0);
    rd("host seq", 1, 8'h00, 32'h0);
    rd("unmapped", 0, 8'h1C, 32'h0);
    check("slverr", {31'h0, errv}, 32'h1);
    rd("host unmapped", 1, 8'h1C, 32'h0);
    check("host slverr", {31'h0, errv}, 32'h1);
    for (int i = 0; i < 11; i++) begin
      apb(0, 1'b1, 8'h04, {23'h0, cfgT[i]});
      apb(1, 1'b1, 8'h00, {24'h0, seqT[i]});
      repeat (20) @(posedge mclk);
      check("outputs", {20'h0, outV}, {20'h0, expT[i]});
      rd("status", 0, 8'h08, {20'h0, expT[i]});
    end
    apb(0, 1'b1, 8'h04, 32'h0);
    apb(1, 1'b1, 8'h00, 32'h1);
    apb(1, 1'b1, 8'h00, 32'h3);
    repeat (2) @(posedge mclk);
    check("early", {31'h0, piOnly}, 32'h0);
    apb(1, 1'b1, 8'h00, 32'h1);
    repeat (20) @(posedge mclk);
    check("glitch", {20'h0, outV}, 32'h002);
    faultEvent <= 1'b1;
    @(posedge mclk);
    faultEvent <= 1'b0;
    repeat (5) @(posedge mclk);
    check("alarm set", {30'h0, outV[1:0]}, 32'h1);
    rd("host alarm", 1, 8'h08, 32'h4);
    apb(1, 1'b1, 8'h00, 32'h41);
    repeat (20) @(posedge mclk);
    check("alarm clr", {30'h0, outV[1:0]}, 32'h2);
    apb(1, 1'b1, 8'h00, 32'h1);
    absPosition <= 32'h1234_ABCD;
    apb(0, 1'b1, 8'h04, 32'h100);
    apb(1, 1'b1, 8'h00, 32'h81);
    poll(32'h2, 32'h2);
    rd("host abs", 1, 8'h10, 32'h1234_ABCD);
    rd("dev abs", 0, 8'h10, 32'h1234_ABCD);
    apb(1, 1'b1, 8'h00, 32'h1);
    for (int f = 0; f < 3; f++) begin
      for (int d = 0; d < 2; d++) begin
        pulses(f[1:0], d[0], 32'h0);
        rd("count", 0, 8'h0C, d ? 32'hFFFF_FFFB : 32'h5);
      end
    end
    rd("host cfg", 1, 8'h04, 32'h2);
    apb(1, 1'b1, 8'h04, 32'h4000_0000);
    repeat (12) @(posedge mclk);
    rd("err clear", 0, 8'h0C, 32'h0);
    apb(1, 1'b1, 8'h00, 32'h3);
    pulses(2'h0, 1'b0, 32'h4);
    rd("inhibit", 0, 8'h0C, 32'h0);
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
endmodule
